/* File: rtl/sarwd_top.sv */
`timescale 1ns/1ns
`include "sarwd_defines.svh"

module sarwd_top
  import sarwd_pkg::*;
#(
  parameter int DIV_W = 5,
  parameter int CODE_W = 10
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic timer0_ovf_in,
  input wire logic timer1_ovf_in,
  input wire logic timer2_ovf_in,
  input wire logic timer3_ovf_in,
  input wire logic external_start_pin_in,
  input wire logic [4:0] negative_input_select_in,
  input wire logic [CODE_W-1:0] sar_code_in,
  output logic converter_enable_out,
  output logic track_out,
  output logic convert_out,
  output logic conversion_clock_out
);

  // ********************
  // Functions
  // ********************
  // unsigned or signed
  function automatic logic word_gt(input logic [15:0] a, input logic [15:0] b, input logic sgn);
    if (sgn) begin
      word_gt = $signed(a) > $signed(b);
    end else begin
      word_gt = a > b;
    end
  endfunction : word_gt

  function automatic logic [15:0] justify(input logic [CODE_W-1:0] code, input logic left);
    if (left) begin
      justify = {code, 6'h00};
    end else begin
      justify = {{(16 - CODE_W){code[CODE_W-1]}}, code};
    end
  endfunction : justify

  // ********************
  // Registers
  // ********************
  logic [DIV_W-1:0] conv_clock_divider_ff;
  logic left_justify_select_ff;
  logic converter_enable_ff;
  logic track_mode_select_ff;
  logic [2:0] start_source_select_ff;
  logic conversion_done_flag_ff;
  logic window_match_flag_ff;
  logic [7:0] result_hi_ff;
  logic [7:0] result_lo_ff;
  logic [15:0] gt_limit_ff;
  logic [15:0] lt_limit_ff;
  sarwd_state_e state_ff;
  sarwd_state_e nxt_state;
  logic [3:0] clk_cnt_ff;
  logic conv_end_ff;
  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_s3_ff;
  logic pin_rise;
  logic div_tick;
  logic div_clear;
  logic trig;
  logic wr_cfg;
  logic wr_ctrl;
  logic busy_wr;
  logic conv_last;
  logic [15:0] new_word;
  logic differential;
  logic win_hit;
  logic busy;

  assign wr_cfg = sfr_wr_in && (sfr_addr_in == `SARWD_ADDR_CLK_CFG);
  assign wr_ctrl = sfr_wr_in && (sfr_addr_in == `SARWD_ADDR_CTRL);
  assign busy = (state_ff != ST_IDLE);

  // ********************
  // Register writes
  // ********************
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conv_clock_divider_ff <= DIV_W'(`SARWD_RST_CLK_CFG >> `SARWD_CFG_DIV_LSB);
      left_justify_select_ff <= 1'b0;
    end else if (wr_cfg) begin
      conv_clock_divider_ff <= sfr_wdata_in[`SARWD_CFG_DIV_MSB:`SARWD_CFG_DIV_LSB];
      left_justify_select_ff <= sfr_wdata_in[`SARWD_CFG_LJST];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      converter_enable_ff <= 1'b0;
      track_mode_select_ff <= 1'b0;
      start_source_select_ff <= 3'h0;
    end else if (wr_ctrl) begin
      converter_enable_ff <= sfr_wdata_in[`SARWD_CTRL_EN];
      track_mode_select_ff <= sfr_wdata_in[`SARWD_CTRL_TM];
      start_source_select_ff <= sfr_wdata_in[`SARWD_CTRL_CM_MSB:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gt_limit_ff <= {`SARWD_RST_LIMIT, `SARWD_RST_LIMIT};
      lt_limit_ff <= {`SARWD_RST_LIMIT, `SARWD_RST_LIMIT};
    end else if (sfr_wr_in) begin
      case (sfr_addr_in)
        `SARWD_ADDR_GT_HI: gt_limit_ff[15:8] <= sfr_wdata_in;
        `SARWD_ADDR_GT_LO: gt_limit_ff[7:0] <= sfr_wdata_in;
        `SARWD_ADDR_LT_HI: lt_limit_ff[15:8] <= sfr_wdata_in;
        `SARWD_ADDR_LT_LO: lt_limit_ff[7:0] <= sfr_wdata_in;
        default: ;
      endcase
    end
  end

  // ********************
  // Start triggers
  // ********************
  // Pin is asynchronous; edge taken only after two stages
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
    end else begin
      pin_s1_ff <= external_start_pin_in;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end
  assign pin_rise = pin_s2_ff && !pin_s3_ff;

  assign busy_wr = wr_ctrl && sfr_wdata_in[`SARWD_CTRL_BUSY];

  always_comb begin
    trig = 1'b0;
    case (start_source_select_ff)
      SRC_BUSY_WRITE: trig = busy_wr;
      SRC_TIMER0: trig = timer0_ovf_in;
      SRC_TIMER2: trig = timer2_ovf_in;
      SRC_TIMER1: trig = timer1_ovf_in;
      SRC_PIN: trig = pin_rise;
      SRC_TIMER3: trig = timer3_ovf_in;
      default: trig = 1'b0;
    endcase
  end

  // ********************
  // Conversion sequencer
  // ********************
  assign conv_last = (state_ff == ST_CONV) && div_tick &&
    (clk_cnt_ff == 4'(`SARWD_CONV_CLKS - 1));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (converter_enable_ff && trig) begin
          if (track_mode_select_ff && (start_source_select_ff != SRC_PIN)) begin
            nxt_state = ST_TRACK;
          end else begin
            nxt_state = ST_CONV;
          end
        end
      end
      ST_TRACK: begin
        if (div_tick && (clk_cnt_ff == 4'(`SARWD_TRACK_CLKS - 1))) begin
          nxt_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_last) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (!converter_enable_ff) begin
      nxt_state = ST_IDLE;
    end
  end

  // Divider restarts on each state change so every phase is whole clocks
  assign div_clear = (state_ff == ST_IDLE) || (nxt_state != state_ff);

  sarwd_conv_clk_div #(
    .DIV_W(DIV_W)
  ) u_div (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .clear_in(div_clear),
    .div_in(conv_clock_divider_ff),
    .tick_out(div_tick)
  );

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_IDLE;
      clk_cnt_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        clk_cnt_ff <= 4'h0;
      end else if (div_tick) begin
        clk_cnt_ff <= clk_cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conv_end_ff <= 1'b0;
    end else begin
      conv_end_ff <= conv_last && converter_enable_ff;
    end
  end

  // ********************
  // Result and window
  // ********************
  // justification of new code
  assign new_word = justify(sar_code_in, left_justify_select_ff);
  assign differential = (negative_input_select_in != `SARWD_NEG_SEL_GND);

  always_comb begin
    if (word_gt(lt_limit_ff, gt_limit_ff, differential)) begin
      win_hit = word_gt(new_word, gt_limit_ff, differential) && word_gt(lt_limit_ff, new_word, differential);
    end else begin
      win_hit = word_gt(new_word, gt_limit_ff, differential) || word_gt(lt_limit_ff, new_word, differential);
    end
  end

  // result bytes; conversion beats software write
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      result_hi_ff <= `SARWD_RST_RES;
      result_lo_ff <= `SARWD_RST_RES;
    end else if (conv_last && converter_enable_ff) begin
      result_hi_ff <= new_word[15:8];
      result_lo_ff <= new_word[7:0];
    end else if (sfr_wr_in && (sfr_addr_in == `SARWD_ADDR_RES_HI)) begin
      result_hi_ff <= sfr_wdata_in;
    end else if (sfr_wr_in && (sfr_addr_in == `SARWD_ADDR_RES_LO)) begin
      result_lo_ff <= sfr_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conversion_done_flag_ff <= 1'b0;
      window_match_flag_ff <= 1'b0;
    end else begin
      if (conv_last && converter_enable_ff) begin
        conversion_done_flag_ff <= 1'b1;
      end else if (wr_ctrl) begin
        conversion_done_flag_ff <= sfr_wdata_in[`SARWD_CTRL_DONE];
      end
      if (conv_last && converter_enable_ff && win_hit) begin
        window_match_flag_ff <= 1'b1;
      end else if (wr_ctrl) begin
        window_match_flag_ff <= sfr_wdata_in[`SARWD_CTRL_WIN];
      end
    end
  end

  // ********************
  // Read path and outputs
  // ********************
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in) begin
      case (sfr_addr_in)
        `SARWD_ADDR_CLK_CFG: sfr_rdata_out <= {conv_clock_divider_ff, left_justify_select_ff, 2'b00};
        `SARWD_ADDR_RES_HI: sfr_rdata_out <= result_hi_ff;
        `SARWD_ADDR_RES_LO: sfr_rdata_out <= result_lo_ff;
        `SARWD_ADDR_GT_HI: sfr_rdata_out <= gt_limit_ff[15:8];
        `SARWD_ADDR_GT_LO: sfr_rdata_out <= gt_limit_ff[7:0];
        `SARWD_ADDR_LT_HI: sfr_rdata_out <= lt_limit_ff[15:8];
        `SARWD_ADDR_LT_LO: sfr_rdata_out <= lt_limit_ff[7:0];
        `SARWD_ADDR_CTRL: sfr_rdata_out <= {converter_enable_ff, track_mode_select_ff,
          conversion_done_flag_ff, busy, window_match_flag_ff, start_source_select_ff};
        default: sfr_rdata_out <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      converter_enable_out <= 1'b0;
      track_out <= 1'b0;
      convert_out <= 1'b0;
      conversion_clock_out <= 1'b0;
    end else begin
      converter_enable_out <= converter_enable_ff;
      convert_out <= (nxt_state == ST_CONV);
      conversion_clock_out <= div_tick;
      if (!converter_enable_ff) begin
        track_out <= 1'b0;
      end else if (!track_mode_select_ff) begin
        track_out <= (nxt_state != ST_CONV);
      end else if (start_source_select_ff == SRC_PIN) begin
        track_out <= (nxt_state == ST_IDLE) && !pin_s2_ff;
      end else begin
        track_out <= (nxt_state == ST_TRACK);
      end
    end
  end

  // ********************
  // Assertions
  // ********************
  logic [15:0] chk_cyc_ff;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      chk_cyc_ff <= 16'h0000;
    end else if (nxt_state != state_ff) begin
      chk_cyc_ff <= 16'h0000;
    end else begin
      chk_cyc_ff <= chk_cyc_ff + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_conv_len;
    (conv_last && !wr_cfg) |-> (chk_cyc_ff == 16'(`SARWD_CONV_CLKS * (conv_clock_divider_ff + 1)));
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_track_len;
    (state_ff == ST_TRACK && nxt_state == ST_CONV && !wr_cfg) |->
      (chk_cyc_ff == 16'(`SARWD_TRACK_CLKS * (conv_clock_divider_ff + 1)));
  endproperty
  a_track_len: assert property (p_track_len) else $error("tracking length wrong");

  property p_tick_gap;
    (div_tick && conv_clock_divider_ff != '0 && !div_clear) |=> !div_tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("conversion clock too fast");

  property p_done_set;
    (conv_last && converter_enable_ff) |=> conversion_done_flag_ff && state_ff == ST_IDLE;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_busy_read;
    (sfr_rd_in && sfr_addr_in == `SARWD_ADDR_CTRL) |=> sfr_rdata_out[`SARWD_CTRL_BUSY] == $past(busy);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit read wrong");

  property p_busy_start;
    (state_ff == ST_IDLE && converter_enable_ff && busy_wr && start_source_select_ff != 3'b000
      && start_source_select_ff != 3'b100 && !timer0_ovf_in && !timer1_ovf_in && !timer2_ovf_in
      && !timer3_ovf_in) |=> state_ff == ST_IDLE;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy write started wrongly");

  property p_disabled;
    !converter_enable_ff |=> state_ff == ST_IDLE && !convert_out;
  endproperty
  a_disabled: assert property (p_disabled) else $error("converter ran while disabled");

  property p_pin_start;
    (state_ff == ST_IDLE && converter_enable_ff && start_source_select_ff == 3'b100 && pin_rise)
      |=> state_ff == ST_CONV ##1 (convert_out && busy);
  endproperty
  a_pin_start: assert property (p_pin_start) else $error("pin edge did not convert");

  property p_justify;
    (conv_last && converter_enable_ff) |=>
      {result_hi_ff, result_lo_ff} == $past(new_word);
  endproperty
  a_justify: assert property (p_justify) else $error("result layout wrong");

  property p_window;
    (conv_last && converter_enable_ff && win_hit) |=> window_match_flag_ff;
  endproperty
  a_window: assert property (p_window) else $error("window flag not set");

  c_conv_done: cover property (conv_end_ff);
  c_track: cover property (state_ff == ST_TRACK && nxt_state == ST_CONV);
  c_window: cover property (conv_end_ff && window_match_flag_ff);
  c_left: cover property (conv_end_ff && left_justify_select_ff && differential);

endmodule : sarwd_top

/* File: rtl/sarwd_defines.svh */
`ifndef SARWD_DEFINES_SVH
`define SARWD_DEFINES_SVH

// ********************
// Register addresses
// ********************
`define SARWD_ADDR_CLK_CFG 8'hbc
`define SARWD_ADDR_RES_LO 8'hbd
`define SARWD_ADDR_RES_HI 8'hbe
`define SARWD_ADDR_GT_LO 8'hc3
`define SARWD_ADDR_GT_HI 8'hc4
`define SARWD_ADDR_LT_LO 8'hc5
`define SARWD_ADDR_LT_HI 8'hc6
`define SARWD_ADDR_CTRL 8'he8

// ********************
// Reset values
// ********************
`define SARWD_RST_CLK_CFG 8'hf8
`define SARWD_RST_CTRL 8'h00
`define SARWD_RST_RES 8'h00
`define SARWD_RST_LIMIT 8'h00

// ********************
// Field positions
// ********************
`define SARWD_CFG_DIV_MSB 7
`define SARWD_CFG_DIV_LSB 3
`define SARWD_CFG_LJST 2
`define SARWD_CTRL_EN 7
`define SARWD_CTRL_TM 6
`define SARWD_CTRL_DONE 5
`define SARWD_CTRL_BUSY 4
`define SARWD_CTRL_WIN 3
`define SARWD_CTRL_CM_MSB 2

// ********************
// Timing and codes
// ********************
`define SARWD_CONV_CLKS 10
`define SARWD_TRACK_CLKS 3
`define SARWD_NEG_SEL_GND 5'h1f

`endif

/* File: rtl/sarwd_pkg.sv */
package sarwd_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TRACK = 2'b01,
    ST_CONV = 2'b10
  } sarwd_state_e;

  typedef enum logic [2:0] {
    SRC_BUSY_WRITE = 3'b000,
    SRC_TIMER0 = 3'b001,
    SRC_TIMER2 = 3'b010,
    SRC_TIMER1 = 3'b011,
    SRC_PIN = 3'b100,
    SRC_TIMER3 = 3'b101
  } sarwd_src_e;

endpackage : sarwd_pkg

/* File: rtl/sarwd_conv_clk_div.sv */
`timescale 1ns/1ns
// One-cycle tick every (div_in + 1) core clocks while not cleared
module sarwd_conv_clk_div #(
  parameter int DIV_W = 5
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic clear_in,
  input wire logic [DIV_W-1:0] div_in,
  output logic tick_out
);

  logic [DIV_W-1:0] cnt_ff;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_ff <= '0;
      tick_out <= 1'b0;
    end else if (clear_in) begin
      cnt_ff <= '0;
      tick_out <= 1'b0;
    end else if (cnt_ff == div_in) begin
      cnt_ff <= '0;
      tick_out <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      tick_out <= 1'b0;
    end
  end

endmodule : sarwd_conv_clk_div

/* File: tb/sarwd_afe_model.sv */
`timescale 1ns/1ns
module sarwd_afe_model (
  input wire logic clk_in,
  input wire logic convert_in,
  input wire logic [9:0] code_in,
  output logic [9:0] sar_code_out
);
  // ****
  // Sampled code
  // ****
  // Inverted outside conversions so an early or late sample shows up
  always_ff @(posedge clk_in) begin
    if (convert_in) begin
      sar_code_out <= code_in;
    end else begin
      sar_code_out <= ~code_in;
    end
  end
endmodule : sarwd_afe_model

/* File: tb/sar_adc_control_window_detect_test.sv */
`timescale 1ns/1ns
`include "sarwd_defines.svh"
module sar_adc_control_window_detect_test
  import sarwd_pkg::*;
;
  logic clk_in, rst_b_in, wr_en, rd, pin, en_o, trk, cnv, tick;
  logic [7:0] addr, wdata, rdata, r, c8;
  logic [3:0] tmr;
  logic [4:0] neg;
  logic [9:0] code, sar_code;
  int n_errors = 0, comparisons = 0, n_cnv = 0, n_trk = 0, n_tick = 0, n_both = 0, t, u;
  logic [15:0] wg [8] = '{16'h0040, 16'h0040, 16'h0080, 16'h0080, 16'hffff, 16'hffff, 16'h0040, 16'h1000};
  logic [15:0] wl [8] = '{16'h0080, 16'h0080, 16'h0040, 16'h0040, 16'h0040, 16'h0040, 16'hffff, 16'h2000};
  logic [9:0] wc [8] = '{10'h060, 10'h090, 10'h090, 10'h060, 10'h3fe, 10'h000, 10'h3fe, 10'h060};
  logic [7:0] wj = 8'h01, wd = 8'h70;
  sarwd_top DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .sfr_addr_in(addr), .sfr_wr_in(wr_en), .sfr_rd_in(rd),
    .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .timer0_ovf_in(tmr[0]), .timer1_ovf_in(tmr[1]),
    .timer2_ovf_in(tmr[2]), .timer3_ovf_in(tmr[3]), .external_start_pin_in(pin),
    .negative_input_select_in(neg), .sar_code_in(sar_code), .converter_enable_out(en_o),
    .track_out(trk), .convert_out(cnv), .conversion_clock_out(tick));
  sarwd_afe_model AFE (.clk_in(clk_in), .convert_in(cnv), .code_in(code), .sar_code_out(sar_code));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    n_cnv <= n_cnv + int'(cnv === 1'b1);
    n_trk <= n_trk + int'(trk === 1'b1);
    n_tick <= n_tick + int'(tick === 1'b1);
    n_both <= n_both + int'((cnv & trk) === 1'b1);
  end
  // ****
  // Helpers
  // ****
  function automatic logic [15:0] just(input logic [9:0] c, input logic lj);
    return lj ? {c, 6'h00} : {{6{c[9]}}, c};
  endfunction : just
  // Flipping the sign bit turns a signed compare into an unsigned one
  function automatic logic win(input logic [15:0] w, g, l, input logic df);
    logic [15:0] x;
    x = {df, 15'h0000};
    w ^= x;
    g ^= x;
    l ^= x;
    return (l > g) ? (w > g && w < l) : (w < l || w > g);
  endfunction : win
  function automatic logic [3:0] tmask(input logic [2:0] s);
    return (s == 3'h1) ? 4'h1 : (s == 3'h3) ? 4'h2 : (s == 3'h2) ? 4'h4 : 4'h8;
  endfunction : tmask
  task automatic end_sim;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask : wr
  // Plain read into r, no compare
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    r = rdata;
  endtask : rd_reg
  task automatic rc(input logic [7:0] a, e);
    rd_reg(a);
    chk(r, e);
  endtask : rc
  task automatic res(input logic [15:0] e);
    rc(`SARWD_ADDR_RES_HI, e[15:8]);
    rc(`SARWD_ADDR_RES_LO, e[7:0]);
  endtask : res
  task automatic wait_done;
    for (int i = 0; i < 100; i++) begin
      rd_reg(`SARWD_ADDR_CTRL);
      if (r[5] === 1'b1) return;
    end
    n_errors++;
    end_sim;
  endtask : wait_done
  task automatic run(input logic [7:0] ctl, input logic [9:0] c);
    code <= c;
    // Start bit acts on the settings already held, so load them first
    wr(`SARWD_ADDR_CTRL, ctl & 8'hef);
    wr(`SARWD_ADDR_CTRL, ctl);
    pin <= 1'b0;
    if (ctl[2:0] == 3'h4) begin
      repeat (4) @(posedge clk_in);
      chk(trk, 1'b1);
      pin <= 1'b1;
      repeat (4) @(posedge clk_in);
    end else if (ctl[2:0] != 3'h0) begin
      @(posedge clk_in);
      tmr <= tmask(ctl[2:0]);
      @(posedge clk_in);
      tmr <= 4'h0;
    end
    rd_reg(`SARWD_ADDR_CTRL);
    chk(r[4], 1'b1);
    wait_done;
  endtask : run
  // ****
  // Main sequence
  // ****
  initial begin
    rst_b_in = 1'b0;
    {wr_en, rd, pin, tmr, addr, wdata, code} = '0;
    neg = 5'h1f;
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rc(`SARWD_ADDR_CLK_CFG, 8'hf8);
    rc(`SARWD_ADDR_CTRL, 8'h00);
    rc(`SARWD_ADDR_RES_HI, 8'h00);
    rc(8'hbb, 8'h00);
    u = n_cnv;
    wr(`SARWD_ADDR_CTRL, 8'h10);
    repeat (30) @(posedge clk_in);
    rc(`SARWD_ADDR_CTRL, 8'h00);
    chk(n_cnv - u, 0);
    chk(en_o, 1'b0);
    // Divider and conversion length
    for (int d = 0; d < 3; d++) begin
      wr(`SARWD_ADDR_CLK_CFG, 8'(d * 8));
      u = n_cnv;
      t = n_tick;
      run(8'h90, 10'h2c5);
      chk(n_cnv - u, 10 * (d + 1) + 1);
      chk(n_tick - t, 10);
      res(just(10'h2c5, 1'b0));
      chk(en_o, 1'b1);
      chk(trk, 1'b1);
    end
    wr(`SARWD_ADDR_CLK_CFG, 8'h07);
    rc(`SARWD_ADDR_CLK_CFG, 8'h04);
    run(8'h90, 10'h2c5);
    res(just(10'h2c5, 1'b1));
    wr(`SARWD_ADDR_CLK_CFG, 8'h00);
    // Every source in both track modes
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 6; s++) begin
        c8 = 8'h80 | 8'(m * 64 + s);
        c8[4] = (s == 0);
        // Let tracking of the previous mode drain before counting
        wr(`SARWD_ADDR_CTRL, c8 & 8'hef);
        repeat (2) @(negedge clk_in);
        t = n_trk;
        run(c8, 10'(9'h155 + s));
        res(just(10'(9'h155 + s), 1'b0));
        if (m == 1 && s != 4) begin
          chk(n_trk - t, 4);
        end
      end
    end
    // Busy write with a timer source and reserved codes
    u = n_cnv;
    for (int s = 5; s < 8; s++) begin
      wr(`SARWD_ADDR_CTRL, 8'h90 | 8'(s));
      tmr <= (s > 5) ? 4'hf : 4'h0;
      @(posedge clk_in);
      tmr <= 4'h0;
      repeat (30) @(posedge clk_in);
      rc(`SARWD_ADDR_CTRL, 8'h80 | 8'(s));
    end
    chk(n_cnv - u, 0);
    // Window table
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_in);
      neg <= wd[k] ? 5'h00 : 5'h1f;
      wr(`SARWD_ADDR_CLK_CFG, {5'h00, wj[k], 2'h0});
      wr(`SARWD_ADDR_GT_HI, wg[k][15:8]);
      wr(`SARWD_ADDR_GT_LO, wg[k][7:0]);
      wr(`SARWD_ADDR_LT_HI, wl[k][15:8]);
      wr(`SARWD_ADDR_LT_LO, wl[k][7:0]);
      run(8'h90, wc[k]);
      repeat (20) @(posedge clk_in);
      rd_reg(`SARWD_ADDR_CTRL);
      chk(r[3], win(just(wc[k], wj[k]), wg[k], wl[k], wd[k]));
      chk(r[5], 1'b1);
      res(just(wc[k], wj[k]));
    end
    chk(n_both, 0);
    end_sim;
  end
endmodule : sar_adc_control_window_detect_test
